// ===== hdl/code_qualifier.sv
/*
  Holds off a recognised control code until it has been seen without
  change for the hold time, counted in DS1 frames.
  Assumes code_i is synchronous to clock_i and frame_tick_i is one cycle wide.
*/
`timescale 1ns/1ps
`default_nettype none
`include "loop_responder_defs.svh"

module code_qualifier
   import loop_pkg::*;
#(
   parameter logic [`CNT_W-1:0] HOLD_FRAMES = `CNT_W'(`HOLD_SEC * `FRAMES_PER_SEC)
) (
   // Clock and control
   input  wire logic  clock_i,
   input  wire logic  nrst_i,
   input  wire logic  ce_i,
   input  wire logic  frame_tick_i,
   // Raw and qualified code
   input  wire code_e code_i,
   output code_e      code_o,
   output logic       new_o
);

   code_e              last;
   code_e              next_last;
   code_e              next_code;
   logic [`CNT_W-1:0]  cnt;
   logic [`CNT_W-1:0]  next_cnt;
   logic               next_new;

   always_comb begin
      next_last = code_i;
      next_cnt  = cnt;
      next_code = code_o;
      next_new  = 1'b0;
      if (code_i != last) begin
         // Any break restarts the hold time
         next_cnt  = '0;
         next_code = code_none;
      end else if (frame_tick_i && cnt != HOLD_FRAMES) begin
         next_cnt = cnt + `CNT_W'(1);
         if (next_cnt == HOLD_FRAMES) begin // R15
            next_code = last;
            next_new  = (last != code_none);
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         last   <= code_none;
         cnt    <= '0;
         code_o <= code_none;
         new_o  <= 1'b0;
      end else if (ce_i) begin
         last   <= next_last;
         cnt    <= next_cnt;
         code_o <= next_code;
         new_o  <= next_new;
      end
   end

endmodule
`default_nettype wire

// ===== hdl/loop_pkg.sv
/*
  Types shared by the loopback code responder files.
  Assumes an upstream recogniser maps in-band and data-link patterns to code_e.
*/
package loop_pkg;

   typedef enum logic [3:0] {
      code_none      = 4'h0,
      code_arm       = 4'h1,
      code_disarm    = 4'h2,
      code_loop_ct   = 4'h3,
      code_loop_rep1 = 4'h4,
      code_loop_rep2 = 4'h5,
      code_loop_rt   = 4'h6,
      code_override  = 4'h7,
      code_span_off  = 4'h8
   } code_e;

   typedef enum logic [1:0] {
      role_central = 2'h0,
      role_rep1    = 2'h1,
      role_rep2    = 2'h2,
      role_remote  = 2'h3
   } role_e;

endpackage

// ===== hdl/loop_responder_defs.svh
/*
  Constants of the span loopback code responder: interval lengths in seconds,
  the DS1 frame length, error burst sizes and the control code patterns.
  Assumes the DS1 frame tick arrives once per 125 us frame.

// Contract
// R1: Override code while armed or looped disables timeout
// R2: Leaving armed state restores previous timeout setting
// R3: Override makes looped element send identifying error burst
// R4: Armed central terminal cuts span power during code
// R5: Code gone: power back, all retrain disarmed unlooped
// R6: First repeater code: loop, ones, data, 10 errors
// R7: First repeater repeats 10 errors every 20 s
// R8: Second repeater code, two repeaters: 200 errors sequence
// R9: Second repeater repeats 200 errors every 20 s
// R10: Remote terminal code when armed: 20 errors sequence
// R11: Remote terminal repeats 20 errors every 10 s
// R12: Code gone keeps loop; its return resumes bursts
// R13: Codes other than arm ignored unless armed
// R14: Act only on codes this element itself receives
// R15: Codes act only after 5 s continuous detection
// R16: Network arm pattern arms all elements
// R17: Disarm from either side disarms and releases loops
// R18: Central terminal code: loop, ones, data, 231 errors
// R19: Intervals counted on recovered DS1 frame timing
*/
`ifndef LOOP_RESPONDER_DEFS_SVH
`define LOOP_RESPONDER_DEFS_SVH

`define FRAME_NS        125000
`define FRAMES_PER_SEC  (1000000000 / `FRAME_NS)
`define HOLD_SEC        5
`define ALLONES_SEC     2
`define LOOPED_SEC      5
`define REPEAT_REP_SEC  20
`define REPEAT_RT_SEC   10
`define CNT_W           18

`define BURST_CT        8'he7
`define BURST_REP1      8'h0a
`define BURST_REP2      8'hc8
`define BURST_RT        8'h14

`define PAT_ARM_INBAND  5'h18
`define PAT_ARM_DL      16'hff48
`define PAT_DISARM_IB   5'h1c
`define PAT_DISARM_DL   16'hff24
`define PAT_LOOP_CT     16'hd3d3
`define PAT_LOOP_REP1   16'hc741
`define PAT_LOOP_REP2   16'hc754
`define PAT_LOOP_RT     16'hc742
`define PAT_OVERRIDE    16'hd5d6
`define PAT_SPAN_OFF    16'h6767

`endif

// ===== hdl/span_loopback_code_responder.sv
/*
  Loopback control code responder of one span element: arm and disarm,
  network-facing loopback with all-ones, looped data and error bursts,
  timeout override and span power disable.
  Assumes upstream recognisers present decoded codes per side, codes seen
  here are those that reach this element, and one frame tick per DS1 frame.
*/
`timescale 1ns/1ps
`default_nettype none
`include "loop_responder_defs.svh"

module span_loopback_code_responder
   import loop_pkg::*;
#(
   parameter logic [`CNT_W-1:0] HOLD_FRAMES    = `CNT_W'(`HOLD_SEC * `FRAMES_PER_SEC),
   parameter logic [`CNT_W-1:0] ALLONES_FRAMES = `CNT_W'(`ALLONES_SEC * `FRAMES_PER_SEC),
   parameter logic [`CNT_W-1:0] LOOPED_FRAMES  = `CNT_W'(`LOOPED_SEC * `FRAMES_PER_SEC),
   parameter logic [`CNT_W-1:0] REP_FRAMES     = `CNT_W'(`REPEAT_REP_SEC * `FRAMES_PER_SEC),
   parameter logic [`CNT_W-1:0] RT_FRAMES      = `CNT_W'(`REPEAT_RT_SEC * `FRAMES_PER_SEC)
) (
   // Clock and control
   input  wire logic  clock_i,
   input  wire logic  nrst_i,
   input  wire logic  ce_i,
   input  wire logic  frame_tick_i,
   // Element position
   input  wire role_e role_i,
   input  wire logic  two_repeaters_i,
   // Decoded codes arriving at this element
   input  wire code_e net_code_i,
   input  wire code_e cust_code_i,
   // Line events and provisioning
   input  wire logic  retrain_i,
   input  wire logic  timeout_cfg_i,
   // Responses
   output logic       armed_o,
   output logic       looped_o,
   output logic       all_ones_o,
   output logic       error_inject_o,
   output logic       timeout_en_o,
   output logic       span_power_off_o
);

   typedef enum logic [5:0] {
      st_disarmed = 6'b000001,
      st_armed    = 6'b000010,
      st_ones     = 6'b000100,
      st_data     = 6'b001000,
      st_burst    = 6'b010000,
      st_wait     = 6'b100000
   } state_e;

   code_e              net_q;
   code_e              cust_q;
   logic               net_new;
   logic               cust_new;
   state_e             state;
   state_e             next_state;
   logic [`CNT_W-1:0]  cnt;
   logic [`CNT_W-1:0]  next_cnt;
   logic [7:0]         errs;
   logic [7:0]         next_errs;
   logic               override;
   logic               next_override;
   logic               next_span_off;
   logic               next_inject;
   logic               is_armed;
   logic               own_code;

   function automatic code_e own_loop_code(input role_e r);
      case (r)
         role_central: own_loop_code = code_loop_ct;
         role_rep1:    own_loop_code = code_loop_rep1;
         role_rep2:    own_loop_code = code_loop_rep2;
         default:      own_loop_code = code_loop_rt;
      endcase
   endfunction

   function automatic logic [7:0] burst_size(input role_e r);
      case (r)
         role_central: burst_size = `BURST_CT;
         role_rep1:    burst_size = `BURST_REP1;
         role_rep2:    burst_size = `BURST_REP2;
         default:      burst_size = `BURST_RT;
      endcase
   endfunction

   code_qualifier #(.HOLD_FRAMES(HOLD_FRAMES)) u_net_qual (
      .clock_i      (clock_i),
      .nrst_i       (nrst_i),
      .ce_i         (ce_i),
      .frame_tick_i (frame_tick_i),
      .code_i       (net_code_i),
      .code_o       (net_q),
      .new_o        (net_new)
   );

   code_qualifier #(.HOLD_FRAMES(HOLD_FRAMES)) u_cust_qual (
      .clock_i      (clock_i),
      .nrst_i       (nrst_i),
      .ce_i         (ce_i),
      .frame_tick_i (frame_tick_i),
      .code_i       (cust_code_i),
      .code_o       (cust_q),
      .new_o        (cust_new)
   );

   assign is_armed  = (state != st_disarmed);
   // Second repeater only answers when a second repeater exists
   assign own_code  = (net_q == own_loop_code(role_i)) &&
                      (role_i != role_rep2 || two_repeaters_i); // R8 R14

   always_comb begin
      next_state    = state;
      next_cnt      = cnt;
      next_errs     = errs;
      next_override = override;
      next_inject   = 1'b0;
      next_span_off = (role_i == role_central) && is_armed &&
                      (net_q == code_span_off); // R4 R13
      if ((net_new && net_q == code_disarm) ||
          (cust_new && cust_q == code_disarm)) begin
         next_state    = st_disarmed; // R17
         next_override = 1'b0; // R2
         next_span_off = 1'b0;
      end else if (retrain_i || (span_power_off_o && !next_span_off)) begin
         // Retrain after span power returns leaves everyone clean
         next_state    = st_disarmed; // R5
         next_override = 1'b0; // R2
      end else begin
         if (is_armed && net_new && net_q == code_override) begin
            next_override = 1'b1; // R1
            // Confirmation only where the loop can carry it now
            if (state == st_data || state == st_wait) begin
               next_state = st_burst; // R3
               next_errs  = burst_size(role_i);
            end
         end
         case (state)
            st_disarmed: begin
               if (net_new && net_q == code_arm) begin
                  next_state = st_armed; // R16
               end
            end
            st_armed: begin
               if (net_new && own_code) begin
                  next_state = st_ones; // R6 R8 R10 R13 R18
                  next_cnt   = '0;
               end
            end
            st_ones: begin
               if (frame_tick_i) begin // R19
                  next_cnt = cnt + `CNT_W'(1);
                  if (next_cnt == ALLONES_FRAMES) begin
                     next_state = st_data;
                     next_cnt   = '0;
                  end
               end
            end
            st_data: begin
               if (frame_tick_i && next_state == st_data) begin
                  next_cnt = cnt + `CNT_W'(1);
                  if (next_cnt == LOOPED_FRAMES) begin
                     next_state = st_burst; // R6 R8 R10 R18
                     next_errs  = burst_size(role_i);
                  end
               end
            end
            st_burst: begin
               // One logic error per frame keeps each error countable
               if (frame_tick_i) begin
                  next_inject = 1'b1;
                  next_errs   = errs - 8'h01;
                  if (next_errs == 8'h00) begin
                     next_state = st_wait;
                     next_cnt   = '0;
                  end
               end
            end
            st_wait: begin
               if (frame_tick_i && cnt != ((role_i == role_remote) ? RT_FRAMES : REP_FRAMES)) begin
                  next_cnt = cnt + `CNT_W'(1); // R19
               end
               // Loop stays while code absent; bursts resume on its return
               if (next_state == st_wait && own_code &&
                   cnt == ((role_i == role_remote) ? RT_FRAMES : REP_FRAMES)) begin
                  next_state = st_burst; // R7 R9 R11 R12
                  next_errs  = burst_size(role_i);
               end
            end
            default: begin
               next_state = st_disarmed;
            end
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         state            <= st_disarmed;
         cnt              <= '0;
         errs             <= 8'h00;
         override         <= 1'b0;
         span_power_off_o <= 1'b0;
         error_inject_o   <= 1'b0;
         armed_o          <= 1'b0;
         looped_o         <= 1'b0;
         all_ones_o       <= 1'b0;
         timeout_en_o     <= 1'b0;
      end else if (ce_i) begin
         state            <= next_state;
         cnt              <= next_cnt;
         errs             <= next_errs;
         override         <= next_override;
         span_power_off_o <= next_span_off;
         error_inject_o   <= next_inject;
         armed_o          <= (next_state != st_disarmed);
         looped_o         <= (next_state != st_disarmed) && (next_state != st_armed);
         all_ones_o       <= (next_state == st_ones);
         // Provisioned setting comes back as soon as override clears
         timeout_en_o     <= timeout_cfg_i && !next_override; // R1 R2
      end
   end

endmodule
`default_nettype wire

// ===== test/net_test_set.sv
/*
  Network test set: frame ticks, codes held whole frames, error tally.
  Assumes one clock shared with the responder.
*/
`timescale 1ns/1ps
`default_nettype none
module net_test_set
   import loop_pkg::*;
#(
   parameter int DIV = 4
) (
   // Control
   input  wire logic   clock_i,
   input  wire logic   nrst_i,
   input  wire code_e  cmd_i,
   input  wire logic   error_i,
   // Line side
   output logic        frame_tick_o,
   output code_e       code_o,
   output logic [15:0] errors_o
);
   logic [7:0] div;
   logic       wrap;
   assign wrap = (div == 8'(DIV - 1));
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         div          <= 8'h00;
         frame_tick_o <= 1'b0;
         code_o       <= code_none;
         errors_o     <= 16'h0000;
      end else begin
         div          <= wrap ? 8'h00 : div + 8'h01;
         frame_tick_o <= wrap;
         // Codes only change on frame boundaries
         if (wrap)
            code_o <= cmd_i;
         if (error_i)
            errors_o <= errors_o + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// ===== test/span_loopback_code_responder_chk.sv
/*
  Port checker of the loopback code responder.
  Assumes it is bound to the responder top.
*/
`timescale 1ns/1ps
`default_nettype none
module span_loopback_code_responder_chk
   import loop_pkg::*;
(
   // Inputs of the responder
   input wire logic  clock_i,
   input wire logic  nrst_i,
   input wire logic  ce_i,
   input wire logic  frame_tick_i,
   input wire role_e role_i,
   input wire logic  two_repeaters_i,
   input wire code_e net_code_i,
   input wire code_e cust_code_i,
   input wire logic  retrain_i,
   input wire logic  timeout_cfg_i,
   // Responses
   input wire logic  armed_o,
   input wire logic  looped_o,
   input wire logic  all_ones_o,
   input wire logic  error_inject_o,
   input wire logic  timeout_en_o,
   input wire logic  span_power_off_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   property p_loop_armed; looped_o |-> armed_o; endproperty
   a_loop_armed: assert property (p_loop_armed) else $error("loop while disarmed");
   property p_ones; all_ones_o |-> looped_o && !error_inject_o; endproperty
   a_ones: assert property (p_ones) else $error("ones outside loop");
   property p_inject; error_inject_o |-> looped_o && $past(frame_tick_i); endproperty
   a_inject: assert property (p_inject) else $error("error off frame");
   property p_arm_cause; $rose(armed_o) |-> $past(net_code_i, 3) == code_arm; endproperty
   a_arm_cause: assert property (p_arm_cause) else $error("arm without code");
   property p_loop_cause; $rose(looped_o) |-> $past(armed_o) && all_ones_o; endproperty
   a_loop_cause: assert property (p_loop_cause) else $error("loop not from arm");
   property p_power_cause;
      $rose(span_power_off_o) |-> role_i == role_central && $past(net_code_i, 3) == code_span_off;
   endproperty
   a_power_cause: assert property (p_power_cause) else $error("power cut no cause");
   property p_power_drop; $fell(span_power_off_o) |-> !armed_o && !looped_o; endproperty
   a_power_drop: assert property (p_power_drop) else $error("power back armed");
   property p_timeout;
      $past(nrst_i) && !$past(armed_o) && !$past(armed_o, 2) && !armed_o
         |-> timeout_en_o == $past(timeout_cfg_i);
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout not restored");
   property p_retrain; retrain_i |-> ##[1:2] !armed_o && !looped_o; endproperty
   a_retrain: assert property (p_retrain) else $error("retrain kept state");
endmodule
bind span_loopback_code_responder span_loopback_code_responder_chk chk_u (
   .clock_i, .nrst_i, .ce_i, .frame_tick_i, .role_i, .two_repeaters_i, .net_code_i,
   .cust_code_i, .retrain_i, .timeout_cfg_i, .armed_o, .looped_o, .all_ones_o,
   .error_inject_o, .timeout_en_o, .span_power_off_o);
`default_nettype wire

// ===== test/test_span_loopback_code_responder.sv
/*
  Self-checking bench of the loopback code responder.
  Assumes shortened intervals and a four-cycle frame.
*/
`timescale 1ns/1ps
`default_nettype none
module test_span_loopback_code_responder;
   import loop_pkg::*;
   localparam int H = 4;
   localparam int A = 3;
   localparam int L = 4;
   localparam int RP = 12;
   localparam int RT = 6;
   logic        clock_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        retrain = 1'b0;
   logic        ce = 1'b1;
   logic        cfg = 1'b1;
   logic        two_rep = 1'b1;
   role_e       role = role_central;
   code_e       cmd = code_none;
   code_e       cust = code_none;
   code_e       net;
   logic        tick, armed, looped, ones, inj, tmo, spoff;
   logic [15:0] errs;
   int          miscompares = 0;
   int          samples_checked = 0;
   always #20 clock_i = ~clock_i;
   net_test_set set_u (.clock_i(clock_i), .nrst_i(nrst_i), .cmd_i(cmd),
      .error_i(inj), .frame_tick_o(tick), .code_o(net), .errors_o(errs));
   span_loopback_code_responder #(.HOLD_FRAMES(18'h4), .ALLONES_FRAMES(18'h3),
      .LOOPED_FRAMES(18'h4), .REP_FRAMES(18'hc), .RT_FRAMES(18'h6)) dut_u (
      .clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce), .frame_tick_i(tick), .role_i(role),
      .two_repeaters_i(two_rep), .net_code_i(net), .cust_code_i(cust), .retrain_i(retrain),
      .timeout_cfg_i(cfg), .armed_o(armed), .looped_o(looped), .all_ones_o(ones),
      .error_inject_o(inj), .timeout_en_o(tmo), .span_power_off_o(spoff));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic ticks(input int n);
      repeat (n * 4) @(posedge clock_i);
   endtask
   // Partner latches at next frame, so holds carry two or three spare frames
   task automatic send(input code_e c, input int n);
      cmd <= c;
      ticks(n);
   endtask
   task automatic arm();
      send(code_arm, H + 3);
      check("armed", 16'(armed), 16'h1);
   endtask
   task automatic disarm();
      cmd  <= code_none;
      cust <= code_disarm;
      ticks(H + 3);
      check("armed", 16'(armed), 16'h0);
      check("looped", 16'(looped), 16'h0);
      check("timeout", 16'(tmo), 16'h1);
      cust <= code_none;
   endtask
   task automatic s_unarmed();
      send(code_loop_ct, H + 3);
      check("looped", 16'(looped), 16'h0);
      send(code_override, H + 3);
      check("timeout", 16'(tmo), 16'h1);
      send(code_arm, H - 2);
      send(code_none, 2);
      check("armed", 16'(armed), 16'h0);
   endtask
   task automatic s_loop(input role_e r, input code_e c, input logic [15:0] b, input int rep,
                         input logic tr);
      logic [15:0] base;
      role    <= r;
      two_rep <= tr;
      arm();
      base = errs;
      send(c, H + 2);
      check("looped", 16'(looped), 16'(tr));
      if (tr) begin
         check("ones", 16'(ones), 16'h1);
         ticks(A + L + b + 2);
         check("burst", errs - base, b);
         ticks(rep + b + 1);
         check("repeat", errs - base, 16'(2 * b));
         send(code_none, rep + b + H);
         check("held", errs - base, 16'(2 * b));
         check("looped", 16'(looped), 16'h1);
         send(c, H + b + 3);
         check("resume", errs - base, 16'(3 * b));
      end
      disarm();
   endtask
   task automatic s_override();
      logic [15:0] base;
      role <= role_remote;
      arm();
      send(code_loop_rt, H + A + L + 24);
      base = errs;
      send(code_override, H + 2);
      check("timeout", 16'(tmo), 16'h0);
      ticks(22);
      check("confirm", errs - base, 16'h0014);
      disarm();
   endtask
   task automatic s_span();
      role <= role_central;
      arm();
      send(code_span_off, H + 2);
      check("power_off", 16'(spoff), 16'h1);
      send(code_none, 2);
      check("power_off", 16'(spoff), 16'h0);
      check("armed", 16'(armed), 16'h0);
   endtask
   // Frames seen while frozen must not count toward a hold time
   task automatic s_freeze();
      arm();
      ce   <= 1'b0;
      cust <= code_disarm;
      ticks(H + 3);
      ce   <= 1'b1;
      cust <= code_none;
      ticks(1);
      check("frozen", 16'(armed), 16'h1);
      disarm();
      cfg <= 1'b0;
      ticks(1);
      check("timeout", 16'(tmo), 16'h0);
      cfg <= 1'b1;
   endtask
   task automatic s_retrain();
      arm();
      retrain <= 1'b1;
      ticks(1);
      retrain <= 1'b0;
      check("armed", 16'(armed), 16'h0);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clock_i);
      nrst_i <= 1'b1;
      s_unarmed();
      s_loop(role_central, code_loop_ct, 16'h00e7, RP, 1'b1);
      s_loop(role_rep1, code_loop_rep1, 16'h000a, RP, 1'b1);
      s_loop(role_rep2, code_loop_rep2, 16'h00c8, RP, 1'b1);
      s_loop(role_rep2, code_loop_rep2, 16'h00c8, RP, 1'b0);
      s_loop(role_remote, code_loop_rt, 16'h0014, RT, 1'b1);
      s_override();
      s_freeze();
      s_span();
      s_retrain();
      complete_run();
   end
   initial begin
      repeat (30000) @(posedge clock_i);
      miscompares++;
      complete_run();
   end
endmodule
`default_nettype wire
